// >>> scc_sync_clamp_irq.v
// Sync clamp, test pattern output and sync change interrupt block
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_sync_clamp_irq (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Register port
   input  wire [7:0]  addr_in,
   input  wire [7:0]  wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [7:0]  rdata_out,
   // Sync pins
   input  wire        hsync_in,
   input  wire        vsync_in,
   // Measurements from the sync processor
   input  wire        meas_strobe_in,
   input  wire        cv_present_in,
   input  wire        h_present_in,
   input  wire        v_present_in,
   input  wire        h_polarity_in,
   input  wire        v_polarity_in,
   input  wire        h_off_level_in,
   input  wire        v_off_level_in,
   input  wire [13:0] h_count_in,
   input  wire [11:0] v_count_in,
   input  wire        h_overflow_in,
   input  wire        v_overflow_in,
   // Self-test pattern generator
   input  wire        crosshatch_in,
   input  wire        test_sync_in,
   output reg         test_gen_enable_out,
   output reg  [1:0]  test_timing_sel_out,
   output reg         pattern_video_out,
   output reg         self_test_sync_out,
   output reg         self_test_sync_oe_out,
   // Clamp pin
   output wire        horizontal_clamp_out,
   output wire        horizontal_clamp_oe_out,
   // Interrupt to the core
   output wire        core_external_irq_request_n_out
);

   // Software registers
   reg  [7:0]  test_pattern_control_r;
   reg  [7:0]  clamp_pulse_control_r;
   reg  [7:0]  sync_event_flags_r;
   reg  [7:0]  sync_event_flags_nxt;
   reg  [7:0]  sync_event_enables_r;
   reg         clamp_output_enable_r;
   reg  [7:0]  rdata_nxt;

   // Pin synchronisers
   reg         hs_meta_r;
   reg         hs_sync_r;
   reg         hs_prev_r;
   reg         vs_meta_r;
   reg         vs_sync_r;
   reg         vs_prev_r;

   // Previous measurement
   reg         h_present_prev_r;
   reg         v_present_prev_r;
   reg         h_polarity_prev_r;
   reg         v_polarity_prev_r;
   reg  [13:0] h_count_prev_r;
   reg  [11:0] v_count_prev_r;
   reg         h_ovf_prev_r;
   reg         v_ovf_prev_r;
   reg         meas_seen_r;

   // Latest measurement, as read back
   reg         h_ovf_stat_r;
   reg         v_ovf_stat_r;

   // One-cycle change pulses
   reg         h_pres_chg_r;
   reg         v_pres_chg_r;
   reg         h_pol_chg_r;
   reg         v_pol_chg_r;
   reg         h_freq_chg_r;
   reg         v_freq_chg_r;

   wire        hs_lead;
   wire        hs_trail;
   wire        vs_lead;
   wire        wr_tpat;
   wire        wr_clamp;
   wire        wr_flags;
   wire        wr_en;
   wire        wr_clen;
   wire [7:0]  event_set;
   wire [7:0]  flag_keep;

   // Register decode used by the write strobes; the read mux decodes with its own case
   function addr_hit;
      input [7:0] a;
      input [7:0] reg_addr;
      begin
         addr_hit = (a == reg_addr);
      end
   endfunction

   // Leading edge means going to the active level of the given polarity
   function is_lead;
      input now_lvl;
      input old_lvl;
      input pol;
      begin
         is_lead = (now_lvl == pol) && (old_lvl != pol);
      end
   endfunction

   // Two flops on each pin before any logic looks at it
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hs_meta_r <= 1'b0;
         hs_sync_r <= 1'b0;
         hs_prev_r <= 1'b0;
         vs_meta_r <= 1'b0;
         vs_sync_r <= 1'b0;
         vs_prev_r <= 1'b0;
      end else begin
         hs_meta_r <= hsync_in;
         hs_sync_r <= hs_meta_r;
         hs_prev_r <= hs_sync_r;
         vs_meta_r <= vsync_in;
         vs_sync_r <= vs_meta_r;
         vs_prev_r <= vs_sync_r;
      end
   end

   // Edge events on the synchronised syncs
   assign hs_lead  = is_lead(hs_sync_r, hs_prev_r, h_polarity_in);
   assign hs_trail = is_lead(hs_sync_r, hs_prev_r, ~h_polarity_in);
   assign vs_lead  = is_lead(vs_sync_r, vs_prev_r, v_polarity_in);

   // Write strobes per register
   assign wr_tpat  = wr_in & addr_hit(addr_in, `SCC_REG_TPAT);
   assign wr_clamp = wr_in & addr_hit(addr_in, `SCC_REG_CLAMP);
   assign wr_flags = wr_in & addr_hit(addr_in, `SCC_REG_FLAGS);
   assign wr_en    = wr_in & addr_hit(addr_in, `SCC_REG_ENABLES);
   assign wr_clen  = wr_in & addr_hit(addr_in, `SCC_REG_CLAMP_EN);

   // Control registers
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         test_pattern_control_r <= `SCC_RST_BYTE;
         clamp_pulse_control_r  <= `SCC_RST_BYTE;
         sync_event_enables_r   <= `SCC_RST_BYTE;
         clamp_output_enable_r  <= 1'b0;
      end else begin
         if (wr_tpat) begin
            test_pattern_control_r <= wdata_in;
         end
         if (wr_clamp) begin
            clamp_pulse_control_r <= wdata_in;
         end
         if (wr_en) begin
            sync_event_enables_r <= wdata_in & `SCC_FL_MASK;
         end
         if (wr_clen) begin
            clamp_output_enable_r <= wdata_in[`SCC_CLEN_BIT];
         end
      end
   end

   // Compare each new measurement with the one before it;
   // the first measurement after reset only primes the history
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         h_present_prev_r  <= 1'b0;
         v_present_prev_r  <= 1'b0;
         h_polarity_prev_r <= 1'b0;
         v_polarity_prev_r <= 1'b0;
         h_count_prev_r    <= 14'h0000;
         v_count_prev_r    <= 12'h000;
         h_ovf_prev_r      <= 1'b0;
         v_ovf_prev_r      <= 1'b0;
         meas_seen_r       <= 1'b0;
         h_pres_chg_r      <= 1'b0;
         v_pres_chg_r      <= 1'b0;
         h_pol_chg_r       <= 1'b0;
         v_pol_chg_r       <= 1'b0;
         h_freq_chg_r      <= 1'b0;
         v_freq_chg_r      <= 1'b0;
      end else begin
         h_pres_chg_r <= 1'b0;
         v_pres_chg_r <= 1'b0;
         h_pol_chg_r  <= 1'b0;
         v_pol_chg_r  <= 1'b0;
         h_freq_chg_r <= 1'b0;
         v_freq_chg_r <= 1'b0;
         if (meas_strobe_in) begin
            meas_seen_r       <= 1'b1;
            h_present_prev_r  <= h_present_in;
            v_present_prev_r  <= v_present_in;
            h_polarity_prev_r <= h_polarity_in;
            v_polarity_prev_r <= v_polarity_in;
            h_count_prev_r    <= h_count_in;
            v_count_prev_r    <= v_count_in;
            h_ovf_prev_r      <= h_overflow_in;
            v_ovf_prev_r      <= v_overflow_in;
            if (meas_seen_r) begin
               h_pres_chg_r <= (h_present_in != h_present_prev_r);
               v_pres_chg_r <= (v_present_in != v_present_prev_r);
               h_pol_chg_r  <= (h_polarity_in != h_polarity_prev_r);
               v_pol_chg_r  <= (v_polarity_in != v_polarity_prev_r);
               // Overflow counts once on entry, not on every measurement
               h_freq_chg_r <= (h_count_in != h_count_prev_r) |
                               (h_overflow_in & ~h_ovf_prev_r);
               v_freq_chg_r <= (v_count_in != v_count_prev_r) |
                               (v_overflow_in & ~v_ovf_prev_r);
            end
         end
      end
   end

   // Overflow status follows the condition with no software clear
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         h_ovf_stat_r <= 1'b0;
         v_ovf_stat_r <= 1'b0;
      end else begin
         h_ovf_stat_r <= h_overflow_in;
         v_ovf_stat_r <= v_overflow_in;
      end
   end

   // Event vector in flag layout
   assign event_set = {h_pres_chg_r, v_pres_chg_r, h_pol_chg_r, v_pol_chg_r,
                       h_freq_chg_r, v_freq_chg_r, 1'b0, vs_lead};

   // Zero bits in a flag write clear, ones keep
   assign flag_keep = wr_flags ? wdata_in : `SCC_ONES_BYTE;

   // Set wins over a clear in the same cycle so no event is lost
   always @* begin
      sync_event_flags_nxt = ((sync_event_flags_r & flag_keep) | event_set) & `SCC_FL_MASK;
   end

   // Sticky flags
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_event_flags_r <= `SCC_RST_BYTE;
      end else begin
         sync_event_flags_r <= sync_event_flags_nxt;
      end
   end

   // Active low level request while any enabled flag stands
   assign core_external_irq_request_n_out =
      ~|(sync_event_flags_r & sync_event_enables_r);

   // Read mux; unmapped and write-only offsets read zero
   always @* begin
      rdata_nxt = `SCC_ZERO_BYTE;
      case (addr_in)
         `SCC_REG_STATUS: begin
            rdata_nxt = {cv_present_in, 1'b0, h_polarity_in, v_polarity_in,
                         h_present_in, v_present_in, h_off_level_in, v_off_level_in};
         end
         `SCC_REG_HCNT_HI: begin
            rdata_nxt = {h_ovf_stat_r, 1'b0, h_count_in[13:8]};
         end
         `SCC_REG_HCNT_LO: begin
            rdata_nxt = h_count_in[7:0];
         end
         `SCC_REG_VCNT_HI: begin
            rdata_nxt = {v_ovf_stat_r, 3'h0, v_count_in[11:8]};
         end
         `SCC_REG_VCNT_LO: begin
            rdata_nxt = v_count_in[7:0];
         end
         `SCC_REG_FLAGS: begin
            rdata_nxt = sync_event_flags_r;
         end
         default: begin
            rdata_nxt = `SCC_ZERO_BYTE;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= `SCC_ZERO_BYTE;
      end else begin
         rdata_out <= rd_in ? rdata_nxt : `SCC_ZERO_BYTE;
      end
   end

   // Test pattern video and self-test sync pin
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         test_gen_enable_out   <= 1'b0;
         test_timing_sel_out   <= 2'h0;
         pattern_video_out     <= 1'b0;
         self_test_sync_out    <= 1'b0;
         self_test_sync_oe_out <= 1'b0;
      end else begin
         test_gen_enable_out <= test_pattern_control_r[`SCC_TP_GEN_EN];
         test_timing_sel_out <= test_pattern_control_r[`SCC_TP_TIM_HI:`SCC_TP_TIM_LO];
         if (!test_pattern_control_r[`SCC_TP_GEN_EN]) begin
            pattern_video_out <= 1'b0;
         end else begin
            case (test_pattern_control_r[`SCC_TP_RT_HI:`SCC_TP_RT_LO])
               `SCC_PAT_XHATCH_POS: pattern_video_out <= crosshatch_in;
               `SCC_PAT_XHATCH_NEG: pattern_video_out <= ~crosshatch_in;
               `SCC_PAT_WHITE:      pattern_video_out <= 1'b1;
               `SCC_PAT_BLACK:      pattern_video_out <= 1'b0;
               default:             pattern_video_out <= 1'b0;
            endcase
         end
         // Pin idles low when not driven so no stale level is seen on enable
         self_test_sync_out    <= test_pattern_control_r[`SCC_TP_OUT_EN] & test_sync_in;
         self_test_sync_oe_out <= test_pattern_control_r[`SCC_TP_OUT_EN];
      end
   end

   // Clamp pulse generator
   scc_clamp_gen u_clamp (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .lead_in      (hs_lead),
      .trail_in     (hs_trail),
      .edge_sel_in  (clamp_pulse_control_r[`SCC_CL_EDGE]),
      .pol_in       (clamp_pulse_control_r[`SCC_CL_POL]),
      .width_in     (clamp_pulse_control_r[`SCC_CL_W_HI:`SCC_CL_W_LO]),
      .out_en_in    (clamp_output_enable_r),
      .clamp_out    (horizontal_clamp_out),
      .clamp_oe_out (horizontal_clamp_oe_out)
   );

endmodule // scc_sync_clamp_irq

// >>> scc_map.vh
// Register map, field positions and timing constants of the sync clamp and change interrupt block
// Summary of operation
// - Pattern type 1,0 gives full white video, 1,1 gives full black video.
// - Self-test sync pin is driven only while the test output enable is 1.
// - Clamp starts at hsync leading edge when edge select is 1, else trailing edge.
// - Clamp pulse is positive when polarity bit is 1, negative when 0.
// - Clamp width is (width field plus one) times 0.167 us; the unit is rounded up to 7 clocks of 25 ns, 0.175 us.
// - Events set their flags; interrupt request is low while an enabled flag is set.
// - Writing 0 to a flag bit clears it; writing 1 leaves it unchanged.
// - A change in detected h or v presence sets its presence change flag.
// - A change in detected h or v polarity sets its polarity change flag.
// - A frequency change or counter overflow sets that sync's frequency flag.
// - Vertical pulse flag reports a pending vsync interrupt; writing 0 clears it.
// - Each of the seven sources has its own enable; only enabled ones interrupt.
// - Vertical pulse flag is set at the leading edge of each vsync pulse.
// - Horizontal clamp pin is driven only while the clamp output enable is set.
// - Counter overflow status bit follows the overflow condition, cleared by hardware.
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// Register offsets, reads
`define SCC_REG_STATUS      8'h40
`define SCC_REG_HCNT_HI     8'h41
`define SCC_REG_HCNT_LO     8'h42
`define SCC_REG_VCNT_HI     8'h43
`define SCC_REG_VCNT_LO     8'h44
// Register offsets, writes and read/write
`define SCC_REG_TPAT        8'h42
`define SCC_REG_CLAMP       8'h43
`define SCC_REG_FLAGS       8'h48
`define SCC_REG_ENABLES     8'h49
`define SCC_REG_CLAMP_EN    8'h4a

// Reset values and byte constants
`define SCC_RST_BYTE        8'h00
`define SCC_ZERO_BYTE       8'h00
`define SCC_ONES_BYTE       8'hff

// Test pattern control fields
`define SCC_TP_GEN_EN       5
`define SCC_TP_TIM_HI       4
`define SCC_TP_TIM_LO       3
`define SCC_TP_RT_HI        2
`define SCC_TP_RT_LO        1
`define SCC_TP_OUT_EN       0
`define SCC_PAT_XHATCH_POS  2'h0
`define SCC_PAT_XHATCH_NEG  2'h1
`define SCC_PAT_WHITE       2'h2
`define SCC_PAT_BLACK       2'h3

// Clamp control fields
`define SCC_CL_EDGE         6
`define SCC_CL_POL          5
`define SCC_CL_W_HI         4
`define SCC_CL_W_LO         2
`define SCC_CLEN_BIT        0

// Flag and enable bit positions
`define SCC_FL_HPR          7
`define SCC_FL_VPR          6
`define SCC_FL_HPL          5
`define SCC_FL_VPL          4
`define SCC_FL_HF           3
`define SCC_FL_VF           2
`define SCC_FL_VP           0
`define SCC_FL_MASK         8'hfd

// Timing
`define SCC_CLK_NS          25
`define SCC_CLAMP_UNIT_NS   167
`define SCC_CLAMP_UNIT_CYC  ((`SCC_CLAMP_UNIT_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CLAMP_CNT_W     6

`endif

// >>> scc_clamp_gen.v
// Clamp pulse generator: edge pick, width timer and output polarity
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_clamp_gen (
   // Clock and reset
   input  wire       clk_in,
   input  wire       rst_n_in,
   // Edge events of the synchronised hsync
   input  wire       lead_in,
   input  wire       trail_in,
   // Control
   input  wire       edge_sel_in,
   input  wire       pol_in,
   input  wire [2:0] width_in,
   input  wire       out_en_in,
   // Pin
   output reg        clamp_out,
   output reg        clamp_oe_out
);

   reg [`SCC_CLAMP_CNT_W-1:0] cnt_r;
   reg [`SCC_CLAMP_CNT_W-1:0] cnt_nxt;
   wire                       start;
   wire                       active;

   // Pulse length in clock cycles for a width code
   function [`SCC_CLAMP_CNT_W-1:0] scc_width_cycles;
      input [2:0] w;
      integer     t;
      begin
         t = ({29'h0000_0000, w} + 1) * `SCC_CLAMP_UNIT_CYC;
         scc_width_cycles = t[`SCC_CLAMP_CNT_W-1:0];
      end
   endfunction

   // Leading or trailing edge starts the pulse
   assign start  = edge_sel_in ? lead_in : trail_in;
   assign active = (cnt_r != {`SCC_CLAMP_CNT_W{1'b0}});

   // A new edge restarts the timer, so on a line shorter than the pulse two pulses merge into one
   always @* begin
      cnt_nxt = cnt_r;
      if (start) begin
         cnt_nxt = scc_width_cycles(width_in);
      end else if (active) begin
         cnt_nxt = cnt_r - {{(`SCC_CLAMP_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Registered pin, idle level follows the polarity
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r        <= {`SCC_CLAMP_CNT_W{1'b0}};
         clamp_out    <= 1'b0;
         clamp_oe_out <= 1'b0;
      end else begin
         cnt_r        <= cnt_nxt;
         clamp_out    <= pol_in ? active : ~active;
         clamp_oe_out <= out_en_in;
      end
   end

endmodule // scc_clamp_gen

// >>> scc_sync_src.sv
// Host sync source and sync measurement model
`timescale 1ns/1ps
module scc_sync_src (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Scenario controls
   input  wire        run_in,
   input  wire        pol_in,
   input  wire [5:0]  per_in,
   // Sync pin and measurement results
   output reg         hsync_out,
   output reg         strobe_out,
   output reg         present_out,
   output reg         polarity_out,
   output reg  [13:0] count_out
);
   reg [5:0] ph_r;
   // Line phase, 8-cycle pulse at line start, one measurement per line
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {ph_r, hsync_out, strobe_out, present_out, polarity_out} <= 10'h000;
         count_out <= 14'h0000;
      end else begin
         ph_r         <= (ph_r >= per_in) ? 6'h00 : ph_r + 6'h01;
         hsync_out    <= (run_in && ph_r < 6'h08) ~^ pol_in; // Idle sits at the off level
         strobe_out   <= (ph_r == 6'h20);
         present_out  <= run_in;
         polarity_out <= pol_in;
         count_out    <= run_in ? {8'h00, per_in} : 14'h0000; // Lost sync reads as zero count
      end
   end
endmodule // scc_sync_src

// >>> scc_sync_clamp_irq_chk.sv
// Port checker of the sync clamp and change interrupt block
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_chk (
   // Clock and reset
   input wire       clk_in,
   input wire       rst_n_in,
   // Register port
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   input wire       wr_in,
   input wire       rd_in,
   input wire [7:0] rdata_out,
   // Event causes
   input wire       meas_strobe_in,
   input wire       vsync_in,
   input wire       h_overflow_in,
   // Watched outputs
   input wire       self_test_sync_out,
   input wire       self_test_sync_oe_out,
   input wire       horizontal_clamp_oe_out,
   input wire       core_external_irq_request_n_out
);
   reg  [2:0] st_r;
   reg  [3:0] vs_r;
   reg  [1:0] tp_r;
   reg  [1:0] ce_r;
   wire       irq_n = core_external_irq_request_n_out;
   wire       quiet = !(|st_r) && (vs_r == {4{vsync_in}});
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Cause history, since flags and enables land a few cycles late
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {st_r, vs_r, tp_r, ce_r} <= 11'h000;
      end else begin
         st_r <= {st_r[1:0], meas_strobe_in};
         vs_r <= {vs_r[2:0], vsync_in};
         tp_r <= {tp_r[0], wr_in && addr_in == `SCC_REG_TPAT};
         ce_r <= {ce_r[0], wr_in && addr_in == `SCC_REG_CLAMP_EN};
      end
   end
   a_rd_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_hovf_read: assert property (
      rd_in && addr_in == `SCC_REG_HCNT_HI |=> rdata_out[7] == $past(h_overflow_in, 2))
      else $error("overflow bit wrong");
   a_test_sync_off: assert property (!self_test_sync_oe_out |-> !self_test_sync_out)
      else $error("self-test sync driven while off");
   a_test_oe_cause: assert property ($changed(self_test_sync_oe_out) |-> |tp_r)
      else $error("self-test enable moved without write");
   a_clamp_oe_cause: assert property ($changed(horizontal_clamp_oe_out) |-> ce_r[1])
      else $error("clamp enable moved without write");
   a_clamp_oe_value: assert property (ce_r[1] |-> horizontal_clamp_oe_out == $past(wdata_in[0], 2))
      else $error("clamp enable wrong");
   a_irq_mask_all: assert property (
      wr_in && addr_in == `SCC_REG_ENABLES && wdata_in == 8'h00 |=> irq_n)
      else $error("request with all sources masked");
   a_irq_clear_all: assert property (
      wr_in && addr_in == `SCC_REG_FLAGS && wdata_in == 8'h00 && quiet |=> irq_n)
      else $error("request after all flags cleared");
   a_irq_fall_cause: assert property ($fell(irq_n) |-> $past(wr_in) || !quiet)
      else $error("request without event or enable");
   c_irq_raised: cover property ($fell(irq_n));
   c_clamp_on: cover property ($rose(horizontal_clamp_oe_out));
   c_flag_read: cover property (rd_in && addr_in == `SCC_REG_FLAGS);
endmodule // scc_chk
bind scc_sync_clamp_irq scc_chk chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .meas_strobe_in(meas_strobe_in), .vsync_in(vsync_in), .h_overflow_in(h_overflow_in),
   .self_test_sync_out(self_test_sync_out), .self_test_sync_oe_out(self_test_sync_oe_out),
   .horizontal_clamp_oe_out(horizontal_clamp_oe_out),
   .core_external_irq_request_n_out(core_external_irq_request_n_out));

// >>> scc_tb.sv
// Self-checking bench of the sync clamp and change interrupt block
`timescale 1ns/1ps
`include "scc_map.vh"
module tb;
   // Expected flags after each event step, step 0 in the low byte
   localparam [103:0] EXP = {8'h20, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00, 8'h04, 8'h10, 8'h40, 8'h88, 8'h88, 8'h08, 8'h20};
   reg         clk_in, rst_n_in, wr_in, rd_in, vsync_in, v_present_in, v_polarity_in;
   reg         h_overflow_in, v_overflow_in, test_sync_in, run_r, pol_r;
   reg  [7:0]  addr_in, wdata_in, e;
   reg  [5:0]  per_r;
   wire [7:0]  rdata_out;
   wire [2:0]  tgt;
   wire [13:0] h_count_in;
   wire        hsync_in, meas_strobe_in, h_present_in, h_polarity_in, pattern_video_out;
   wire        self_test_sync_out, self_test_sync_oe_out, horizontal_clamp_out, horizontal_clamp_oe_out, irq_n;
   integer     error_cnt, checks_done, i, n, q, k, m;
   scc_sync_clamp_irq dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .hsync_in(hsync_in), .vsync_in(vsync_in), .meas_strobe_in(meas_strobe_in),
      .cv_present_in(1'b0), .h_present_in(h_present_in), .v_present_in(v_present_in),
      .h_polarity_in(h_polarity_in), .v_polarity_in(v_polarity_in), .h_off_level_in(1'b0), .v_off_level_in(1'b0),
      .h_count_in(h_count_in), .v_count_in(12'h000), .h_overflow_in(h_overflow_in), .v_overflow_in(v_overflow_in),
      .crosshatch_in(1'b0), .test_sync_in(test_sync_in), .test_gen_enable_out(tgt[2]), .test_timing_sel_out(tgt[1:0]),
      .pattern_video_out(pattern_video_out), .self_test_sync_out(self_test_sync_out),
      .self_test_sync_oe_out(self_test_sync_oe_out), .horizontal_clamp_out(horizontal_clamp_out),
      .horizontal_clamp_oe_out(horizontal_clamp_oe_out), .core_external_irq_request_n_out(irq_n));
   scc_sync_src src (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_r), .pol_in(pol_r), .per_in(per_r),
      .hsync_out(hsync_in), .strobe_out(meas_strobe_in), .present_out(h_present_in),
      .polarity_out(h_polarity_in), .count_out(h_count_in));
   // Free-running 40 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task nap(input integer c);
      repeat (c) @(negedge clk_in);
   endtask
   task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One-cycle strobes, launched just after a rising edge
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(posedge clk_in);
         wr_in    <= 1'b1;
         addr_in  <= a;
         wdata_in <= v;
         @(posedge clk_in);
         wr_in    <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp, input [63:0] nm);
      begin
         @(posedge clk_in);
         rd_in   <= 1'b1;
         addr_in <= a;
         @(posedge clk_in);
         rd_in   <= 1'b0;
         @(negedge clk_in);
         chk(rdata_out, exp, nm);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, error_cnt);
         if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // One change on the sync side per step; vsync idles opposite its polarity
   task ev(input integer s);
      begin
         @(posedge clk_in);
         case (s)
            0: pol_r <= 1'b0;
            1: per_r <= 6'h2f;
            2: run_r <= 1'b0;
            3: run_r <= 1'b1;
            4: v_present_in <= 1'b1;
            5: {v_polarity_in, vsync_in} <= 2'h1;
            6: v_overflow_in <= 1'b1;
            7: v_overflow_in <= 1'b0;
            8: h_overflow_in <= 1'b1;
            9: h_overflow_in <= 1'b0;
            10: vsync_in <= 1'b0;
            11: vsync_in <= 1'b1;
            default: pol_r <= 1'b1;
         endcase
      end
   endtask
   // Times the clamp from a rising hsync: delay to start, then width
   task clamp(input ed, input p, input [2:0] w, input [7:0] dly);
      begin
         wr(`SCC_REG_CLAMP, {1'b0, ed, p, w, 2'b00});
         nap(70);
         for (n = 0; hsync_in === 1'b1 && n < 200; n = n + 1) nap(1);
         for (q = 0; hsync_in === 1'b0 && q < 200; q = q + 1) nap(1);
         for (k = 0; horizontal_clamp_out !== p && k < 100; k = k + 1) nap(1);
         for (m = 0; horizontal_clamp_out === p && m < 100; m = m + 1) nap(1);
         if (n >= 200 || q >= 200 || k >= 100 || m >= 100) begin
            error_cnt = error_cnt + 1;
            give_verdict;
         end else begin
            chk(k, dly, "clamp_at");
            chk(m, (w + 1) * `SCC_CLAMP_UNIT_CYC, "clamp_w");
         end
      end
   endtask
   // Hang guard
   initial begin
      #500000;
      error_cnt = error_cnt + 1;
      give_verdict;
   end
   initial begin
      {rst_n_in, wr_in, rd_in, vsync_in, v_present_in, h_overflow_in, v_overflow_in, test_sync_in} = 8'h00;
      {v_polarity_in, run_r, pol_r, addr_in, wdata_in} = 19'h7_0000;
      per_r = 6'h3f;
      error_cnt = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      nap(150);
      rdc(`SCC_REG_FLAGS, 8'h00, "flag_rst");
      chk(irq_n, 1'b1, "irq_rst");
      // Pattern select, timing select and self-test sync enable
      @(posedge clk_in) test_sync_in <= 1'b1;
      wr(`SCC_REG_TPAT, 8'h2c);
      nap(3);
      chk(pattern_video_out, 1'b1, "white");
      chk(tgt, 3'h5, "tp_sel");
      chk({self_test_sync_oe_out, self_test_sync_out}, 8'h00, "st_off");
      wr(`SCC_REG_TPAT, 8'h27);
      nap(3);
      chk(pattern_video_out, 1'b0, "black");
      chk(tgt, 3'h4, "tp_sel");
      chk({self_test_sync_oe_out, self_test_sync_out}, 8'h03, "st_on");
      // Inverted cross-hatch of a low input reads high; pin released again
      wr(`SCC_REG_TPAT, 8'h22);
      nap(3);
      chk(pattern_video_out, 1'b1, "xhatch_n");
      chk({self_test_sync_oe_out, self_test_sync_out}, 8'h00, "st_off");
      $display("test pattern done");
      // Each event alone: flag, mask, enable, keep, clear
      for (i = 0; i < 13; i = i + 1) begin
         e = EXP[8*i +: 8];
         ev(i);
         nap(140);
         rdc(`SCC_REG_FLAGS, e, "flags");
         if (i >= 6 && i <= 9)
            rdc(i < 8 ? `SCC_REG_VCNT_HI : `SCC_REG_HCNT_HI, {~i[0], 7'h00}, "ovf");
         chk(irq_n, 1'b1, "irq_off");
         wr(`SCC_REG_ENABLES, ~e & `SCC_FL_MASK);
         nap(1);
         chk(irq_n, 1'b1, "irq_mask");
         wr(`SCC_REG_ENABLES, e);
         nap(1);
         chk(irq_n, e == 8'h00, "irq_on");
         wr(`SCC_REG_FLAGS, 8'hff);
         rdc(`SCC_REG_FLAGS, e, "flg_keep");
         wr(`SCC_REG_FLAGS, i[0] ? ~e : 8'h00);
         nap(1);
         chk(irq_n, 1'b1, "irq_clr");
         rdc(`SCC_REG_FLAGS, 8'h00, "flag_clr");
         // Mask all, so the next step starts with no source enabled
         wr(`SCC_REG_ENABLES, 8'h00);
      end
      $display("test events done");
      // Clamp enable, edge, polarity and width
      wr(`SCC_REG_CLAMP_EN, 8'h01);
      nap(2);
      chk(horizontal_clamp_oe_out, 1'b1, "clamp_oe");
      per_r <= 6'h3f;
      clamp(1'b1, 1'b1, 3'h0, 8'h04);
      clamp(1'b1, 1'b1, 3'h7, 8'h04);
      clamp(1'b0, 1'b1, 3'h0, 8'h0c);
      clamp(1'b1, 1'b0, 3'h2, 8'h04);
      wr(`SCC_REG_CLAMP_EN, 8'h00);
      nap(2);
      chk(horizontal_clamp_oe_out, 1'b0, "clamp_oe");
      $display("test clamp done");
      give_verdict;
   end
endmodule // tb
